// ### dv/sfw_host_model.sv
// Serial host model: mode 0 frames, bytes MSB first.
// Assumes the caller waits for each send to return before the next.
`timescale 1ns/1ps
module sfw_host_model
(
	input  wire logic i_mclk,
	output logic      o_sclk,
	output logic      o_cs_n,
	output logic      o_si
);
	int ph = 4;
	initial
	begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_si   = 1'b0;
	end
	task automatic half();
		repeat (ph) @(posedge i_mclk);
		#1;
	endtask
	task automatic clk_bit(input logic b);
		o_si = b;
		half();
		o_sclk = 1'b1;
		half();
		o_sclk = 1'b0;
	endtask
	// Extra bits model a host that deselects off the byte boundary
	task automatic send(input logic [7:0] q[$], input int extra);
		half();
		o_cs_n = 1'b0;
		foreach (q[i])
			for (int k = 7; k >= 0; k--)
				clk_bit(q[i][k]);
		for (int k = 0; k < extra; k++)
			clk_bit(~o_si);
		half();
		o_cs_n = 1'b1;
		o_si = ~o_si;
		repeat (4) half();
	endtask
endmodule

// ### dv/sfw_seq_assertions.sv
// Port checker for the flash write sequencer.
// Assumes protect bits stay still while a frame is open.
`timescale 1ns/1ps
module sfw_seq_assertions
	import sfw_pkg::*;
(
	input wire logic        i_mclk,
	input wire logic        i_resetn,
	input wire logic        i_sclk,
	input wire logic        i_cs_n,
	input wire logic        i_si,
	input wire logic [4:0]  i_protect_bits,
	input wire logic [23:0] i_rd_addr,
	input wire logic [23:0] o_rd_next_addr,
	input wire logic        o_wrap_enable,
	input wire logic [1:0]  o_wrap_size_bits,
	input wire logic        o_write_latch_flag,
	input wire logic        o_busy_flag,
	input wire logic        o_op_start,
	input wire logic [1:0]  o_op_kind,
	input wire logic [23:0] o_op_addr,
	input wire logic        o_wr_valid,
	input wire logic [23:0] o_wr_addr,
	input wire logic [7:0]  o_wr_data
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);
	logic [23:0] base_mask;
	assign base_mask = (o_op_kind == OP_SECTOR) ? SECTOR_MASK : (o_op_kind == OP_BLOCK32) ? BLOCK32_MASK : BLOCK64_MASK;
	function automatic logic [23:0] next_rd(input logic [23:0] a, input logic en, input logic [1:0] sz);
		logic [23:0] m;
		m = {16'h0, (8'h08 << sz) - 8'h01};
		next_rd = en ? ((a & ~m) | ((a + 24'h1) & m)) : a + 24'h1;
	endfunction
	sequence s_start;
		o_op_start;
	endsequence
	// Timer is at least 40 cycles, so 8 is a safe floor
	sequence s_busy_hold;
		o_busy_flag[*8];
	endsequence
	start_needs_latch_a: assert property (s_start |-> $past(o_write_latch_flag) && !$past(o_busy_flag))
		else $error("start without latch or while busy");
	start_effects_a: assert property (s_start |-> !o_write_latch_flag ##0 s_busy_hold)
		else $error("start without busy or with latch set");
	start_pulse_a: assert property (s_start |=> !o_op_start)
		else $error("start pulse too long");
	busy_no_latch_a: assert property (o_busy_flag |-> !o_write_latch_flag)
		else $error("latch set while busy");
	wr_in_busy_a: assert property (o_wr_valid |-> o_busy_flag && o_op_kind == OP_PAGE)
		else $error("byte write outside a page cycle");
	wr_same_page_a: assert property (o_wr_valid |-> o_wr_addr[23:8] == o_op_addr[23:8])
		else $error("byte write left its page");
	clear_aligned_a: assert property (o_op_start && o_op_kind != OP_PAGE |-> (o_op_addr & base_mask) == 24'h0)
		else $error("clear base not aligned");
	protect_top_a: assert property (o_op_start && i_protect_bits == 5'h01 |-> o_op_addr < 24'h070000)
		else $error("protected region started");
	rd_wrap_a: assert property ($past(i_resetn) && $stable(o_wrap_enable) && $stable(o_wrap_size_bits)
		|-> o_rd_next_addr == next_rd($past(i_rd_addr), o_wrap_enable, o_wrap_size_bits))
		else $error("next read address wrong");
endmodule
bind sfw_seq sfw_seq_assertions sfw_seq_assertions_inst (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_sclk(i_sclk),
	.i_cs_n(i_cs_n), .i_si(i_si), .i_protect_bits(i_protect_bits), .i_rd_addr(i_rd_addr),
	.o_rd_next_addr(o_rd_next_addr), .o_wrap_enable(o_wrap_enable), .o_wrap_size_bits(o_wrap_size_bits),
	.o_write_latch_flag(o_write_latch_flag), .o_busy_flag(o_busy_flag), .o_op_start(o_op_start),
	.o_op_kind(o_op_kind), .o_op_addr(o_op_addr), .o_wr_valid(o_wr_valid), .o_wr_addr(o_wr_addr),
	.o_wr_data(o_wr_data));

// ### dv/tb_top.sv
// Testbench for the flash write sequencer.
// Assumes shortened timer parameters of 40 cycles each.
`timescale 1ns/1ps
module tb_top;
	import sfw_pkg::*;
	typedef struct {logic [7:0] wb; logic [23:0] a; logic [23:0] e;} sfw_row_type;
	logic mclk, resetn, sclk, cs_n, si, wrap_en, latch, busy, op_start, wr_valid;
	logic [4:0] protect;
	logic [23:0] rd_addr, rd_next, op_addr, wr_addr;
	logic [1:0] wrap_size, op_kind;
	logic [7:0] wr_data;
	logic [23:0] wa[$];
	logic [7:0] wd[$];
	logic [7:0] q[$];
	int err_count, checked, starts, busy_len, bad;
	sfw_row_type rows[5] = '{'{8'h00, 24'h001237, 24'h001230}, '{8'h20, 24'h00225f, 24'h002250},
		'{8'h40, 24'h00323e, 24'h00323f}, '{8'h60, 24'h0042ff, 24'h0042c0}, '{8'h10, 24'h0052ff, 24'h005300}};
	logic [7:0] clr_op[3] = '{OPC_SECTOR_CLEAR, OPC_BLOCK32_CLEAR, OPC_BLOCK64_CLEAR};
	logic [23:0] clr_base[3] = '{24'h01a000, 24'h018000, 24'h010000};
	sfw_seq #(.PAGE_WRITE_TIME_NS(1000), .SECTOR_CLEAR_TIME_NS(1000), .BLOCK_CLEAR_TIME_NS(1000)) sfw_seq_inst (
		.i_mclk(mclk), .i_resetn(resetn), .i_sclk(sclk), .i_cs_n(cs_n), .i_si(si), .i_protect_bits(protect),
		.i_rd_addr(rd_addr), .o_rd_next_addr(rd_next), .o_wrap_enable(wrap_en), .o_wrap_size_bits(wrap_size),
		.o_write_latch_flag(latch), .o_busy_flag(busy), .o_op_start(op_start), .o_op_kind(op_kind),
		.o_op_addr(op_addr), .o_wr_valid(wr_valid), .o_wr_addr(wr_addr), .o_wr_data(wr_data));
	sfw_host_model sfw_host_model_inst (.i_mclk(mclk), .o_sclk(sclk), .o_cs_n(cs_n), .o_si(si));
	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		if (wr_valid === 1'b1)
		begin
			wa.push_back(wr_addr);
			wd.push_back(wr_data);
		end
		if (op_start === 1'b1)
			starts++;
		if (busy === 1'b1)
			busy_len++;
	end
	task automatic results();
		$display("Comparisons %0d, mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input bit ok, input string m);
		checked++;
		if (!ok)
		begin
			$display("CHECK FAILED at %0t: %s", $time, m);
			err_count++;
		end
	endtask
	// Bounded: a stuck busy flag ends the run
	task automatic wait_idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 2000)
		begin
			@(posedge mclk);
			#1;
			n++;
		end
		if (n >= 2000)
		begin
			chk(0, "busy never fell");
			results();
		end
	endtask
	initial
	begin
		resetn = 1'b0;
		protect = 5'h00;
		rd_addr = 24'h0;
		repeat (4) @(posedge mclk);
		#1 resetn = 1'b1;
		repeat (8) @(posedge mclk);
		chk(latch === 1'b0 && busy === 1'b0 && wrap_en === 1'b0 && op_start === 1'b0, "reset values");
		foreach (rows[i])
		begin
			sfw_host_model_inst.send({OPC_WRAP_SET, 8'h00, 8'h00, 8'h00, rows[i].wb}, 0);
			rd_addr = rows[i].a;
			repeat (2) @(posedge mclk);
			#1;
			chk(wrap_en === ~rows[i].wb[4] && wrap_size === rows[i].wb[6:5], "wrap setting");
			chk(rd_next === rows[i].e, "next read address");
		end
		sfw_host_model_inst.send({OPC_PAGE_WRITE, 8'h00, 8'h00, 8'h10, 8'h55}, 0);
		chk(starts == 0 && latch === 1'b0, "write without latch ran");
		sfw_host_model_inst.send({OPC_WRITE_UNLOCK}, 0);
		chk(latch === 1'b1, "unlock");
		wa = {};
		wd = {};
		sfw_host_model_inst.send({OPC_PAGE_WRITE, 8'h00, 8'h01, 8'hfe, 8'ha5, 8'h3c, 8'h5a}, 0);
		wait_idle();
		chk(starts == 1 && op_kind === OP_PAGE && op_addr === 24'h0001fe && latch === 1'b0, "page start");
		chk(wa.size() == 3 && busy_len >= 43, "page byte count");
		if (wa.size() == 3)
			chk(wa[0] === 24'h000100 && wd[0] === 8'h5a && wa[1] === 24'h0001fe && wd[1] === 8'ha5
				&& wa[2] === 24'h0001ff && wd[2] === 8'h3c, "page wrap bytes");
		sfw_host_model_inst.send({OPC_WRITE_UNLOCK}, 0);
		wa = {};
		wd = {};
		q = {OPC_PAGE_WRITE, 8'h00, 8'h02, 8'h00};
		for (int k = 0; k < 257; k++)
			q.push_back(8'(k) ^ ((k > 255) ? 8'h80 : 8'h00));
		sfw_host_model_inst.send(q, 0);
		wait_idle();
		bad = 0;
		foreach (wa[i])
			if (wa[i] !== (24'h000200 | 24'(i)) || wd[i] !== ((i == 0) ? 8'h80 : 8'(i)))
				bad++;
		chk(wa.size() == 256 && bad == 0 && starts == 2, "last 256 bytes kept");
		protect = 5'h01;
		sfw_host_model_inst.send({OPC_WRITE_UNLOCK}, 0);
		sfw_host_model_inst.send({OPC_PAGE_WRITE, 8'h07, 8'hff, 8'h00, 8'h11}, 0);
		sfw_host_model_inst.send({OPC_SECTOR_CLEAR, 8'h07, 8'h01, 8'h23}, 0);
		sfw_host_model_inst.send({OPC_BLOCK64_CLEAR, 8'h07, 8'hff, 8'hff}, 0);
		chk(starts == 2 && latch === 1'b1, "protected region ran");
		protect = 5'h00;
		sfw_host_model_inst.send({OPC_SECTOR_CLEAR, 8'h01, 8'h23, 8'h45}, 1);
		sfw_host_model_inst.send({OPC_PAGE_WRITE, 8'h00, 8'h03, 8'h00, 8'h11}, 3);
		chk(starts == 2 && latch === 1'b1, "misframed command ran");
		sfw_host_model_inst.ph = 6;
		for (int k = 0; k < 3; k++)
		begin
			sfw_host_model_inst.send({OPC_WRITE_UNLOCK}, 0);
			busy_len = 0;
			sfw_host_model_inst.send({clr_op[k], 8'h01, 8'ha3, 8'h45}, 0);
			wait_idle();
			chk(starts == 3 + k && op_kind === 2'(k + 1) && op_addr === clr_base[k], "clear start");
			chk(busy_len >= 40 && busy_len <= 45 && latch === 1'b0, "clear busy length");
		end
		results();
	end
endmodule

// ### logic/sfw_page_buf.sv
// Page buffer: 256 bytes, one write port, registered read port.
// Assumes writer and reader never address it in conflicting ways.
`timescale 1ns/1ps
module sfw_page_buf
(
	input  wire logic       i_mclk,
	input  wire logic       i_we,
	input  wire logic [7:0] i_waddr,
	input  wire logic [7:0] i_wdata,
	input  wire logic [7:0] i_raddr,
	output logic      [7:0] o_rdata
);
	logic [7:0] mem [0:255];
	logic [7:0] rdata_reg;

	always_ff @(posedge i_mclk)
	begin
		if (i_we)
			mem[i_waddr] <= i_wdata;
		rdata_reg <= mem[i_raddr];
	end

	assign o_rdata = rdata_reg;
endmodule

// ### logic/sfw_pkg.sv
// Constants and types shared by the serial flash write sequencer.
// Assumes a 24-bit address space with a 512KB array at its bottom.
package sfw_pkg;
	localparam int          CLK_PERIOD_NS      = 25;
	localparam logic [7:0]  OPC_WRITE_UNLOCK   = 8'h06;
	localparam logic [7:0]  OPC_WRAP_SET       = 8'h77;
	localparam logic [7:0]  OPC_PAGE_WRITE     = 8'h02;
	localparam logic [7:0]  OPC_SECTOR_CLEAR   = 8'h20;
	localparam logic [7:0]  OPC_BLOCK32_CLEAR  = 8'h52;
	localparam logic [7:0]  OPC_BLOCK64_CLEAR  = 8'hd8;
	localparam logic [2:0]  BIT_LAST           = 3'h7;
	localparam logic [1:0]  ADDR_LAST_BYTE     = 2'h2;
	localparam logic [1:0]  WRAP_BYTE_IDX      = 2'h3;
	localparam int          WRAP_DISABLE_POS   = 4;
	localparam int          WRAP_SIZE_LSB      = 5;
	localparam logic        WRAP_DISABLE_RST   = 1'b1;
	localparam logic [1:0]  WRAP_SIZE_RST      = 2'h0;
	localparam logic [15:0] WRAP_MIN_LEN       = 16'h0008;
	localparam logic [23:0] MEM_TOP            = 24'h07ffff;
	localparam logic [23:0] PAGE_MASK          = 24'h0000ff;
	localparam logic [23:0] SECTOR_MASK        = 24'h000fff;
	localparam logic [23:0] BLOCK32_MASK       = 24'h007fff;
	localparam logic [23:0] BLOCK64_MASK       = 24'h00ffff;
	localparam logic [23:0] PROT_FINE_SPAN     = 24'h001000;
	localparam logic [23:0] PROT_COARSE_SPAN   = 24'h010000;

	typedef enum logic [1:0] {
		OP_PAGE    = 2'b00,
		OP_SECTOR  = 2'b01,
		OP_BLOCK32 = 2'b10,
		OP_BLOCK64 = 2'b11
	} sfw_op_type;

	typedef enum logic [2:0] {
		FS_OPCODE = 3'b000,
		FS_ADDR   = 3'b001,
		FS_DATA   = 3'b010,
		FS_WRAP   = 3'b011,
		FS_SKIP   = 3'b100
	} sfw_frame_type;

	typedef enum logic [1:0] {
		EX_IDLE = 2'b00,
		EX_WALK = 2'b01,
		EX_WAIT = 2'b10
	} sfw_exec_type;
endpackage

// ### logic/sfw_seq.sv
// Serial flash write sequencer: wrap setting, page write, sector and block clear.
// Assumes the serial clock is slower than a quarter of i_mclk; the array
// sits outside and takes o_op_start and the o_wr_* byte stream.
`timescale 1ns/1ps
module sfw_seq
	import sfw_pkg::*;
#(
	parameter int PAGE_WRITE_TIME_NS   = 700000,
	parameter int SECTOR_CLEAR_TIME_NS = 50000000,
	parameter int BLOCK_CLEAR_TIME_NS  = 150000000
)
(
	input  wire logic        i_mclk,
	input  wire logic        i_resetn,
	input  wire logic        i_sclk,
	input  wire logic        i_cs_n,
	input  wire logic        i_si,
	input  wire logic [4:0]  i_protect_bits,
	input  wire logic [23:0] i_rd_addr,
	output logic      [23:0] o_rd_next_addr,
	output logic             o_wrap_enable,
	output logic      [1:0]  o_wrap_size_bits,
	output logic             o_write_latch_flag,
	output logic             o_busy_flag,
	output logic             o_op_start,
	output logic      [1:0]  o_op_kind,
	output logic      [23:0] o_op_addr,
	output logic             o_wr_valid,
	output logic      [23:0] o_wr_addr,
	output logic      [7:0]  o_wr_data
);
	// Least times round up to whole cycles
	localparam logic [31:0] PAGE_WRITE_CYCLES   =
		32'((PAGE_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [31:0] SECTOR_CLEAR_CYCLES =
		32'((SECTOR_CLEAR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [31:0] BLOCK_CLEAR_CYCLES  =
		32'((BLOCK_CLEAR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	function automatic logic is_write_op(input logic [7:0] opc);
		is_write_op = (opc == OPC_PAGE_WRITE) || (opc == OPC_SECTOR_CLEAR) ||
			(opc == OPC_BLOCK32_CLEAR) || (opc == OPC_BLOCK64_CLEAR);
	endfunction

	function automatic sfw_op_type op_of(input logic [7:0] opc);
		unique case (opc)
			OPC_SECTOR_CLEAR:  op_of = OP_SECTOR;
			OPC_BLOCK32_CLEAR: op_of = OP_BLOCK32;
			OPC_BLOCK64_CLEAR: op_of = OP_BLOCK64;
			default:           op_of = OP_PAGE;
		endcase
	endfunction

	function automatic logic [23:0] region_mask(input sfw_op_type kind);
		unique case (kind)
			OP_PAGE:    region_mask = PAGE_MASK;
			OP_SECTOR:  region_mask = SECTOR_MASK;
			OP_BLOCK32: region_mask = BLOCK32_MASK;
			OP_BLOCK64: region_mask = BLOCK64_MASK;
		endcase
	endfunction

	// Bits 2:0 protect 2^(n-1) spans, none for 0; bit 3 protects from the bottom, bit 4 picks fine spans
	function automatic logic prot_hit(input logic [4:0] bp, input logic [23:0] a);
		logic [23:0] span;
		logic [23:0] off;
		span = (bp[4] ? PROT_FINE_SPAN : PROT_COARSE_SPAN) << (bp[2:0] - 3'h1);
		off  = bp[3] ? (a & MEM_TOP) : (MEM_TOP - (a & MEM_TOP));
		prot_hit = (bp[2:0] != 3'h0) && (off < span);
	endfunction

	function automatic logic [23:0] wrap_next(input logic [23:0] a, input logic dis,
		input logic [1:0] size);
		logic [7:0] lenm;
		logic [7:0] inc;
		lenm = 8'((WRAP_MIN_LEN << size) - 16'h0001);
		inc  = a[7:0] + 8'h01;
		if (dis)
			wrap_next = a + 24'h000001;
		else
			wrap_next = {a[23:8], (a[7:0] & ~lenm) | (inc & lenm)};
	endfunction

	logic [2:0]    pins_s;
	logic          sclk_s;
	logic          cs_n_s;
	logic          si_s;
	logic          sclk_prev_reg;
	logic          cs_n_prev_reg;
	logic          sclk_rise;
	logic          cs_rise;
	logic          selected;
	logic          byte_done;
	logic [7:0]    rx_byte;

	sfw_sync #(
		.WIDTH     (3),
		.RESET_VAL (3'h2)
	) u_sync (
		.i_mclk   (i_mclk),
		.i_resetn (i_resetn),
		.i_d      ({i_sclk, i_cs_n, i_si}),
		.o_q      (pins_s)
	);

	assign sclk_s    = pins_s[2];
	assign cs_n_s    = pins_s[1];
	assign si_s      = pins_s[0];
	assign selected  = !cs_n_s;
	assign sclk_rise = sclk_s && !sclk_prev_reg;
	assign cs_rise   = cs_n_s && !cs_n_prev_reg;

	// Frame state
	sfw_frame_type fstate_reg;
	sfw_frame_type fstate_next;
	logic [2:0]    bit_cnt_reg;
	logic [2:0]    bit_cnt_next;
	logic [7:0]    shift_reg;
	logic [7:0]    shift_next;
	logic [1:0]    byte_cnt_reg;
	logic [1:0]    byte_cnt_next;
	logic [7:0]    cmd_reg;
	logic [7:0]    cmd_next;
	logic [23:0]   addr_reg;
	logic [23:0]   addr_next;
	logic [7:0]    data_idx_reg;
	logic [7:0]    data_idx_next;
	logic [255:0]  mask_reg;
	logic [255:0]  mask_next;
	logic          arm_reg;
	logic          arm_next;
	logic          wrap_disable_reg;
	logic          wrap_disable_next;
	logic [1:0]    wrap_size_reg;
	logic [1:0]    wrap_size_next;
	logic          latch_reg;
	logic          latch_next;
	logic          go;
	logic          buf_we;
	logic [7:0]    buf_waddr;
	logic [7:0]    buf_wdata;
	logic [23:0]   reg_lo;
	logic [23:0]   reg_hi;
	logic          busy;

	assign rx_byte   = {shift_reg[6:0], si_s};
	assign byte_done = sclk_rise && selected && (bit_cnt_reg == BIT_LAST);
	assign reg_lo    = addr_reg & ~region_mask(op_of(cmd_reg));
	assign reg_hi    = addr_reg | region_mask(op_of(cmd_reg));

	always_comb
	begin
		fstate_next       = fstate_reg;
		bit_cnt_next      = bit_cnt_reg;
		shift_next        = shift_reg;
		byte_cnt_next     = byte_cnt_reg;
		cmd_next          = cmd_reg;
		addr_next         = addr_reg;
		data_idx_next     = data_idx_reg;
		mask_next         = mask_reg;
		arm_next          = arm_reg;
		wrap_disable_next = wrap_disable_reg;
		wrap_size_next    = wrap_size_reg;
		latch_next        = latch_reg;
		go                = 1'b0;
		buf_we            = 1'b0;
		buf_waddr         = data_idx_reg;
		buf_wdata         = rx_byte;
		// Any extra clock edge breaks byte alignment and disarms the command
		if (sclk_rise && selected)
		begin
			shift_next   = rx_byte;
			bit_cnt_next = bit_cnt_reg + 3'h1;
			arm_next     = 1'b0;
		end
		if (byte_done)
		begin
			unique case (fstate_reg)
				FS_OPCODE:
				begin
					cmd_next    = rx_byte;
					fstate_next = FS_SKIP;
					if (rx_byte == OPC_WRITE_UNLOCK)
						arm_next = !busy;
					else if (rx_byte == OPC_WRAP_SET && !busy)
						fstate_next = FS_WRAP;
					else if (is_write_op(rx_byte) && latch_reg && !busy)
						fstate_next = FS_ADDR;
				end
				FS_ADDR:
				begin
					addr_next     = {addr_reg[15:0], rx_byte};
					byte_cnt_next = byte_cnt_reg + 2'h1;
					if (byte_cnt_reg == ADDR_LAST_BYTE)
					begin
						if (cmd_reg == OPC_PAGE_WRITE)
						begin
							fstate_next   = FS_DATA;
							data_idx_next = rx_byte;
							mask_next     = '0;
						end
						else
						begin
							arm_next    = 1'b1;
							fstate_next = FS_SKIP;
						end
					end
				end
				FS_DATA:
				begin
					// Index wraps in the page; later bytes overwrite earlier ones
					buf_we                  = 1'b1;
					mask_next[data_idx_reg] = 1'b1;
					data_idx_next           = data_idx_reg + 8'h01;
					arm_next                = 1'b1;
				end
				FS_WRAP:
				begin
					byte_cnt_next = byte_cnt_reg + 2'h1;
					if (byte_cnt_reg == WRAP_BYTE_IDX)
					begin
						wrap_disable_next = rx_byte[WRAP_DISABLE_POS];
						wrap_size_next    = rx_byte[WRAP_SIZE_LSB +: 2];
						fstate_next       = FS_SKIP;
					end
				end
				FS_SKIP:
				begin
				end
			endcase
		end
		if (cs_rise && arm_reg)
		begin
			if (cmd_reg == OPC_WRITE_UNLOCK)
				latch_next = 1'b1;
			else if (!prot_hit(i_protect_bits, reg_lo) && !prot_hit(i_protect_bits, reg_hi))
			begin
				go         = 1'b1;
				latch_next = 1'b0;
			end
		end
		// Deselect ends the frame whatever its state
		if (!selected)
		begin
			fstate_next   = FS_OPCODE;
			bit_cnt_next  = 3'h0;
			byte_cnt_next = 2'h0;
			arm_next      = 1'b0;
		end
	end

	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			sclk_prev_reg    <= 1'b0;
			cs_n_prev_reg    <= 1'b1;
			fstate_reg       <= FS_OPCODE;
			bit_cnt_reg      <= 3'h0;
			shift_reg        <= 8'h00;
			byte_cnt_reg     <= 2'h0;
			cmd_reg          <= 8'h00;
			addr_reg         <= 24'h000000;
			data_idx_reg     <= 8'h00;
			mask_reg         <= '0;
			arm_reg          <= 1'b0;
			wrap_disable_reg <= WRAP_DISABLE_RST;
			wrap_size_reg    <= WRAP_SIZE_RST;
			latch_reg        <= 1'b0;
		end
		else
		begin
			sclk_prev_reg    <= sclk_s;
			cs_n_prev_reg    <= cs_n_s;
			fstate_reg       <= fstate_next;
			bit_cnt_reg      <= bit_cnt_next;
			shift_reg        <= shift_next;
			byte_cnt_reg     <= byte_cnt_next;
			cmd_reg          <= cmd_next;
			addr_reg         <= addr_next;
			data_idx_reg     <= data_idx_next;
			mask_reg         <= mask_next;
			arm_reg          <= arm_next;
			wrap_disable_reg <= wrap_disable_next;
			wrap_size_reg    <= wrap_size_next;
			latch_reg        <= latch_next;
		end
	end

	// Execution state
	sfw_exec_type  xstate_reg;
	sfw_exec_type  xstate_next;
	logic [8:0]    walk_idx_reg;
	logic [8:0]    walk_idx_next;
	logic          pend_reg;
	logic          pend_next;
	logic [7:0]    pend_idx_reg;
	logic [7:0]    pend_idx_next;
	logic [31:0]   timer_reg;
	logic [31:0]   timer_next;
	sfw_op_type    op_kind_reg;
	sfw_op_type    op_kind_next;
	logic [23:0]   op_addr_reg;
	logic [23:0]   op_addr_next;
	logic          start_reg;
	logic          start_next;
	logic          wr_valid_reg;
	logic          wr_valid_next;
	logic [23:0]   wr_addr_reg;
	logic [23:0]   wr_addr_next;
	logic [7:0]    wr_data_reg;
	logic [7:0]    wr_data_next;
	logic [7:0]    buf_rdata;

	sfw_page_buf u_buf (
		.i_mclk  (i_mclk),
		.i_we    (buf_we),
		.i_waddr (buf_waddr),
		.i_wdata (buf_wdata),
		.i_raddr (walk_idx_reg[7:0]),
		.o_rdata (buf_rdata)
	);

	assign busy = (xstate_reg != EX_IDLE);

	always_comb
	begin
		xstate_next   = xstate_reg;
		walk_idx_next = walk_idx_reg;
		pend_next     = 1'b0;
		pend_idx_next = walk_idx_reg[7:0];
		timer_next    = timer_reg;
		op_kind_next  = op_kind_reg;
		op_addr_next  = op_addr_reg;
		start_next    = 1'b0;
		// Only bytes actually received reach the array
		wr_valid_next = pend_reg && mask_reg[pend_idx_reg];
		wr_addr_next  = {op_addr_reg[23:8], pend_idx_reg};
		wr_data_next  = buf_rdata;
		unique case (xstate_reg)
			EX_IDLE:
			begin
				if (go)
				begin
					op_kind_next  = op_of(cmd_reg);
					op_addr_next  = (op_of(cmd_reg) == OP_PAGE) ? addr_reg : reg_lo;
					start_next    = 1'b1;
					walk_idx_next = 9'h000;
					if (op_of(cmd_reg) == OP_PAGE)
						xstate_next = EX_WALK;
					else
					begin
						xstate_next = EX_WAIT;
						timer_next  = (op_of(cmd_reg) == OP_SECTOR) ?
							SECTOR_CLEAR_CYCLES : BLOCK_CLEAR_CYCLES;
					end
				end
			end
			EX_WALK:
			begin
				pend_next = !walk_idx_reg[8];
				if (!walk_idx_reg[8])
					walk_idx_next = walk_idx_reg + 9'h001;
				else if (!pend_reg)
				begin
					xstate_next = EX_WAIT;
					timer_next  = PAGE_WRITE_CYCLES;
				end
			end
			EX_WAIT:
			begin
				if (timer_reg <= 32'h00000001)
					xstate_next = EX_IDLE;
				else
					timer_next = timer_reg - 32'h00000001;
			end
			default:
				xstate_next = EX_IDLE;
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			xstate_reg   <= EX_IDLE;
			walk_idx_reg <= 9'h000;
			pend_reg     <= 1'b0;
			pend_idx_reg <= 8'h00;
			timer_reg    <= 32'h00000000;
			op_kind_reg  <= OP_PAGE;
			op_addr_reg  <= 24'h000000;
			start_reg    <= 1'b0;
			wr_valid_reg <= 1'b0;
			wr_addr_reg  <= 24'h000000;
			wr_data_reg  <= 8'h00;
		end
		else
		begin
			xstate_reg   <= xstate_next;
			walk_idx_reg <= walk_idx_next;
			pend_reg     <= pend_next;
			pend_idx_reg <= pend_idx_next;
			timer_reg    <= timer_next;
			op_kind_reg  <= op_kind_next;
			op_addr_reg  <= op_addr_next;
			start_reg    <= start_next;
			wr_valid_reg <= wr_valid_next;
			wr_addr_reg  <= wr_addr_next;
			wr_data_reg  <= wr_data_next;
		end
	end

	// Wrapped read address stepping for the read path
	logic [23:0] rd_next_reg;
	logic [23:0] rd_next_next;

	always_comb
	begin
		rd_next_next = wrap_next(i_rd_addr, wrap_disable_reg, wrap_size_reg);
	end

	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
			rd_next_reg <= 24'h000000;
		else
			rd_next_reg <= rd_next_next;
	end

	assign o_rd_next_addr     = rd_next_reg;
	assign o_wrap_enable      = !wrap_disable_reg;
	assign o_wrap_size_bits   = wrap_size_reg;
	assign o_write_latch_flag = latch_reg;
	assign o_busy_flag        = busy;
	assign o_op_start         = start_reg;
	assign o_op_kind          = op_kind_reg;
	assign o_op_addr          = op_addr_reg;
	assign o_wr_valid         = wr_valid_reg;
	assign o_wr_addr          = wr_addr_reg;
	assign o_wr_data          = wr_data_reg;
endmodule

// ### logic/sfw_sync.sv
// Two-stage synchroniser for pins from the serial host.
// Assumes the pins are quasi-static across a few system clocks.
`timescale 1ns/1ps
module sfw_sync
#(
	parameter int         WIDTH     = 1,
	parameter logic [2:0] RESET_VAL = 3'h0
)
(
	input  wire logic             i_mclk,
	input  wire logic             i_resetn,
	input  wire logic [WIDTH-1:0] i_d,
	output logic      [WIDTH-1:0] o_q
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] q_reg;

	always_ff @(posedge i_mclk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			meta_reg <= WIDTH'(RESET_VAL);
			q_reg    <= WIDTH'(RESET_VAL);
		end
		else
		begin
			meta_reg <= i_d;
			q_reg    <= meta_reg;
		end
	end

	assign o_q = q_reg;
endmodule
